/* File: core/ldm_demux.sv */
// latched value demultiplexer: edge-captured integer routed to one of four held outputs
`timescale 1ns/1ps
`default_nettype none

module ldm_demux import ldm_pkg::*; #(
  parameter logic [LDM_WORD_W-1:0] FIRST_INDEX = LDM_FIRST_INDEX_DEFAULT,
  parameter logic RETAIN = LDM_RETAIN_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire ldm_capture_t capIn,
  input wire logic powerResume,
  output ldm_outs_t outs_q,
  output logic captureHit_q
);

  // ==========================================================
  // input conditioning
  // kept combinational: every input already shares the clock
  logic [LDM_WORD_W-1:0] addrEff;
  logic [LDM_WORD_W-1:0] valueEff;
  logic [LDM_WORD_W:0] offset;
  logic inRange;
  logic [LDM_SLOT_W-1:0] slot;

  always_comb begin
    addrEff = capIn.addrConnected ? capIn.address : LDM_UNCONNECTED_VALUE;
    valueEff = capIn.valueConnected ? capIn.value : LDM_UNCONNECTED_VALUE;
    // widened so a window near the top of the range cannot wrap
    offset = {1'b0, addrEff} - {1'b0, FIRST_INDEX};
    inRange = (addrEff >= FIRST_INDEX) &&
              (offset < (LDM_WORD_W+1)'(LDM_NUM_OUTS));
    slot = offset[LDM_SLOT_W-1:0];
  end

  // ==========================================================
  // strobe edge detect
  // reset low: a strobe already high at release counts as an edge
  logic strobe_q;
  logic strobe_d;
  logic strobeRise;

  always_comb begin
    strobe_d = capIn.strobe;
    strobeRise = capIn.strobe && !strobe_q;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
    end
  end

  // ==========================================================
  // output latches
  // hit pulse lets cascaded banks be told apart downstream
  ldm_outs_t outs_d;
  logic captureHit_d;
  logic doCapture;

  always_comb begin
    doCapture = strobeRise && inRange;
    outs_d = outs_q;
    if (powerResume && !RETAIN) begin
      for (int k = 0; k < LDM_NUM_OUTS; k++) begin
        outs_d[k] = LDM_OUT_RESET;
      end
    end
    // capture after the clear so a same-cycle write is not lost
    // copy into matching output
    if (doCapture) begin
      outs_d[slot] = valueEff;
    end
    captureHit_d = doCapture;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      for (int k = 0; k < LDM_NUM_OUTS; k++) begin
        outs_q[k] <= LDM_OUT_RESET;
      end
      captureHit_q <= 1'b0;
    end else begin
      outs_q <= outs_d;
      captureHit_q <= captureHit_d;
    end
  end

  // ==========================================================
  // checks
  // written slot takes the value
  a_capture_writes: assert property (
    @(posedge sys_clk) disable iff (rst)
    (capIn.strobe && !strobe_q && inRange)
      |=> (outs_q[$past(slot)] == $past(valueEff)) && captureHit_q
  ) else $error("captured value missing from addressed output");

  a_single_edge: assert property (
    @(posedge sys_clk) disable iff (rst)
    (capIn.strobe && strobe_q) |=> !captureHit_q
  ) else $error("capture seen without a strobe rising edge");

  for (genvar g = 0; g < LDM_NUM_OUTS; g++) begin : gHold
    a_slot_hold: assert property (
      @(posedge sys_clk) disable iff (rst)
      (!(doCapture && slot == g) && !(powerResume && !RETAIN))
        |=> $stable(outs_q[g])
    ) else $error("output changed without a write to its address");
  end

  // first index maps to slot zero
  a_first_index: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise && addrEff == FIRST_INDEX)
      |=> outs_q[0] == $past(valueEff)
  ) else $error("first index did not land in first output");

  a_window_only: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise && !inRange && !(powerResume && !RETAIN))
      |=> $stable(outs_q) && !captureHit_q
  ) else $error("address outside window changed outputs");

  a_resume_policy: assert property (
    @(posedge sys_clk) disable iff (rst)
    (powerResume && !doCapture)
      |=> (RETAIN ? (outs_q == $past(outs_q)) : (outs_q == '0))
  ) else $error("resume did not follow retention option");

  a_unconn_zero: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise && inRange && !capIn.valueConnected)
      |=> outs_q[$past(slot)] == LDM_OUT_RESET
  ) else $error("unconnected value did not store zero");

  a_reset_clear: assert property (
    @(posedge sys_clk)
    rst |=> (outs_q == '0) && !captureHit_q
  ) else $error("outputs not cleared by reset");

  // ==========================================================
  // checks on edges, hits and window bounds

  a_edge_register: assert property (
    @(posedge sys_clk) disable iff (rst)
    !$past(rst) |-> (strobe_q == $past(capIn.strobe))
  ) else $error("strobe edge register lost a sample");

  a_hit_single: assert property (
    @(posedge sys_clk) disable iff (rst)
    captureHit_q |=> !captureHit_q
  ) else $error("capture hit stood longer than one cycle");

  a_hit_cause: assert property (
    @(posedge sys_clk) disable iff (rst)
    captureHit_q |-> $past(capIn.strobe && !strobe_q && inRange)
  ) else $error("capture hit without an addressed strobe edge");

  a_hit_quiet: assert property (
    @(posedge sys_clk) disable iff (rst)
    !(capIn.strobe && !strobe_q) |=> !captureHit_q
  ) else $error("capture hit without a strobe rising edge");

  a_quiet_hold: assert property (
    @(posedge sys_clk) disable iff (rst)
    (!strobeRise && !(powerResume && !RETAIN)) |=> $stable(outs_q)
  ) else $error("outputs changed without a strobe edge");

  a_unconn_addr: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise && !capIn.addrConnected)
      |=> captureHit_q == (FIRST_INDEX == LDM_UNCONNECTED_VALUE)
  ) else $error("unconnected address not taken as zero");

  a_last_index: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise &&
     ({1'b0, addrEff} == {1'b0, FIRST_INDEX} + (LDM_WORD_W+1)'(LDM_NUM_OUTS-1)))
      |=> outs_q[LDM_NUM_OUTS-1] == $past(valueEff)
  ) else $error("top window address did not land in last output");

  a_above_window: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise &&
     ({1'b0, addrEff} >= {1'b0, FIRST_INDEX} + (LDM_WORD_W+1)'(LDM_NUM_OUTS)))
      |=> !captureHit_q
  ) else $error("address above window was captured");

  a_below_window: assert property (
    @(posedge sys_clk) disable iff (rst)
    (strobeRise && (addrEff < FIRST_INDEX)) |=> !captureHit_q
  ) else $error("address below window was captured");

endmodule

`default_nettype wire

/* File: core/ldm_pkg.sv */
// shared constants and carrier types for the latched value demultiplexer
`default_nettype none
package ldm_pkg;

  // ==========================================================
  // widths and counts
  localparam int LDM_WORD_W = 16;
  localparam int LDM_NUM_OUTS = 4;
  localparam int LDM_SLOT_W = 2;

  // ==========================================================
  // reset and default values
  localparam logic [LDM_WORD_W-1:0] LDM_OUT_RESET = 16'h0000;
  localparam logic [LDM_WORD_W-1:0] LDM_UNCONNECTED_VALUE = 16'h0000;
  localparam logic [LDM_WORD_W-1:0] LDM_FIRST_INDEX_DEFAULT = 16'h0000;
  localparam logic LDM_RETAIN_DEFAULT = 1'b1;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic strobe;
    logic addrConnected;
    logic valueConnected;
    logic [LDM_WORD_W-1:0] address;
    logic [LDM_WORD_W-1:0] value;
  } ldm_capture_t;

  typedef logic [LDM_NUM_OUTS-1:0][LDM_WORD_W-1:0] ldm_outs_t;

endpackage

`default_nettype wire

/* File: testbench/ldm_source.sv */
// upstream block model driving the shared capture inputs
`timescale 1ns/1ps
`default_nettype none
module ldm_source import ldm_pkg::*; (
  input wire logic sys_clk,
  input wire logic fire,
  input wire logic [1:0] conn,
  input wire logic [15:0] addr,
  input wire logic [15:0] val,
  output ldm_capture_t capIn
);
  initial capIn = '0;
  always @(negedge sys_clk) begin
    capIn.strobe <= fire;
    capIn.addrConnected <= conn[1];
    capIn.valueConnected <= conn[0];
    capIn.address <= conn[1] ? addr : ~capIn.address;
    capIn.value <= conn[0] ? val : ~capIn.value;
  end
endmodule
`default_nettype wire

/* File: testbench/testbench.sv */
// bench for two cascaded demultiplexers on one source
`timescale 1ns/1ps
`default_nettype none
module testbench import ldm_pkg::*;;
  logic sys_clk = 1'b0, rst = 1'b1, pwr = 1'b0, fire = 1'b0;
  logic [1:0] conn = 2'h3;
  logic [15:0] addr = 16'h0000, val = 16'h0000;
  logic [15:0] exp [8];
  ldm_capture_t capIn;
  ldm_outs_t outsA, outsB;
  logic hitA, hitB;
  int errors = 0, samples_checked = 0, hits = 0, expHits = 0, seed = 32'h8aa3;
  always #2.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) hits <= hits + int'(hitA) + int'(hitB);
  ldm_source ldm_source_i (.sys_clk, .fire, .conn, .addr, .val, .capIn);
  ldm_demux #(.FIRST_INDEX(16'h0000), .RETAIN(1'b1)) ldm_demux_i (.sys_clk, .rst, .capIn,
    .powerResume(pwr), .outs_q(outsA), .captureHit_q(hitA));
  ldm_demux #(.FIRST_INDEX(16'h0004), .RETAIN(1'b0)) ldm_demux_hi_i (.sys_clk, .rst, .capIn,
    .powerResume(pwr), .outs_q(outsB), .captureHit_q(hitB));
  task automatic check(string name, logic [15:0] seen, logic [15:0] want);
    samples_checked++;
    if (seen !== want) begin
      errors++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic compare_all();
    for (int k = 0; k < 4; k++) begin
      check("low bank", outsA[k], exp[k]);
      check("high bank", outsB[k], exp[k+4]);
    end
  endtask
  task automatic clear_exp(int lo);
    for (int k = lo; k < 8; k++) exp[k] = 16'h0000;
  endtask
  // slot over both banks, -1 when outside
  function automatic int exp_index(logic [15:0] a, logic [1:0] c);
    logic [15:0] eff;
    eff = c[1] ? a : 16'h0000;
    return (eff < 16'h0008) ? int'(eff[2:0]) : -1;
  endfunction
  function automatic logic [15:0] exp_value(logic [15:0] v, logic [1:0] c);
    return c[0] ? v : 16'h0000;
  endfunction
  // hold keeps the strobe high while the value moves
  task automatic cap(logic [15:0] a, logic [15:0] v, logic [1:0] c, bit hold);
    fire <= 1'b1;
    addr <= a;
    val <= v;
    conn <= c;
    @(negedge sys_clk);
    if (hold) begin
      val <= ~v;
      repeat (2) @(negedge sys_clk);
    end
    fire <= 1'b0;
    repeat (3) @(negedge sys_clk);
    if (exp_index(a, c) >= 0) begin
      exp[exp_index(a, c)] = exp_value(v, c);
      expHits++;
    end
    compare_all();
  endtask
  task automatic stop_test();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clear_exp(0);
    repeat (20) @(negedge sys_clk);
    rst <= 1'b0;
    @(negedge sys_clk);
    compare_all();
    cap(16'h0002, 16'h1234, 2'h3, 1'b0);
    cap(16'h0007, 16'hBEEF, 2'h3, 1'b1);
    cap(16'h0005, 16'hCAFE, 2'h1, 1'b0);
    cap(16'h0003, 16'h5555, 2'h2, 1'b0);
    cap(16'h0008, 16'h7777, 2'h3, 1'b0);
    repeat (60) cap(16'($unsigned($random(seed)) % 10), 16'($random(seed)),
      2'($random(seed)) | 2'h1, 1'($random(seed)));
    pwr <= 1'b1;
    @(negedge sys_clk);
    pwr <= 1'b0;
    clear_exp(4);
    @(negedge sys_clk);
    compare_all();
    cap(16'h0004, 16'h0F0F, 2'h3, 1'b0);
    rst <= 1'b1;
    @(negedge sys_clk);
    rst <= 1'b0;
    clear_exp(0);
    @(negedge sys_clk);
    compare_all();
    check("hit count", 16'(hits), 16'(expHits));
    stop_test();
  end
  initial begin
    #200000;
    errors++;
    stop_test();
  end
endmodule
`default_nettype wire
